// ===== design/hbc_pkg.sv
// Constants, register map and state codes for the bridge host controller.
// Assumes a 125 MHz system clock and a plain strobe-based register port.
package hbc_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int CLK_HZ            = 125_000_000;
  localparam int CLK_MHZ           = 125;
  localparam int NS_PER_US         = 1000;
  localparam int PWM_FREQ_HZ       = 20_000;
  localparam int PWM_PERIOD_CYC    = CLK_HZ / PWM_FREQ_HZ;
  localparam int TOGGLE_TIME_NS    = 1000;
  localparam int TOGGLE_CYC_RAW    =
    (TOGGLE_TIME_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
  localparam int TOGGLE_CYC        = (TOGGLE_CYC_RAW < 1) ? 1 : TOGGLE_CYC_RAW;
  localparam int ALL_LOW_DELAY_WINDOW_NS = 1000;
  localparam int ALL_LOW_CYC_RAW   =
    (ALL_LOW_DELAY_WINDOW_NS * CLK_MHZ) / NS_PER_US;
  localparam int ALL_LOW_CYC       = (ALL_LOW_CYC_RAW < 1) ? 1 : ALL_LOW_CYC_RAW;

  localparam int CNT_W             = 16;
  localparam int LEGS              = 2;
  localparam int REL_W             = 4;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_DUTY   = 8'h04;
  localparam logic [7:0] ADDR_CMD    = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;

  localparam int CTRL_DIR_LSB  = 0;
  localparam int CTRL_EN_LSB   = 2;
  localparam int CMD_RESTART   = 0;
  localparam int CMD_STANDBY   = 1;
  localparam int CMD_WAKE      = 2;
  localparam int ST_DIAG_LSB   = 0;
  localparam int ST_FAULT_LSB  = 2;
  localparam int ST_ELEM_LSB   = 4;

  localparam logic [LEGS-1:0]  DIAG_RESET = 2'h3;
  localparam logic [31:0]      RD_ZERO    = 32'h0000_0000;

  // ****************************************************************
  // Sequencer states
  // ****************************************************************
  typedef enum logic [3:0] {
    ST_RUN     = 4'h1,
    ST_TG_LOW  = 4'h2,
    ST_TG_HIGH = 4'h4,
    ST_STANDBY = 4'h8
  } hbc_state_type;

endpackage : hbc_pkg

// ===== design/hbc_sync.sv
// Three-stage input sampler for the diagnostic lines.
// Assumes inputs are asynchronous to CLK; output moves once stages 2 and 3
// agree.
`timescale 1ns/10ps
module hbc_sync
  import hbc_pkg::*;
#(
  parameter int              WIDTH     = LEGS,
  parameter logic [WIDTH-1:0] RESET_VAL = DIAG_RESET
) (
  input  wire logic             clk,    // System clock
  input  wire logic             ce,     // Clock enable
  input  wire logic             reset,  // Sync reset, high
  input  wire logic [WIDTH-1:0] din,    // Raw pin levels
  output logic      [WIDTH-1:0] dout    // Qualified levels
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] q;
  } hbc_sync_type;

  hbc_sync_type st;
  hbc_sync_type next_st;

  always_comb begin
    next_st    = st;
    next_st.s1 = din;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (st.s2[i] == st.s3[i]) begin
        next_st.q[i] = st.s3[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st <= {RESET_VAL, RESET_VAL, RESET_VAL, RESET_VAL};
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign dout = st.q;

endmodule : hbc_sync

// ===== design/hbc_top.sv
// Host-side controller for a full-bridge driver with latched leg faults.
// Assumes external pull-ups on both diagnostic lines and a strobe master.
//
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/10ps

// What this block does
// - Only pull diag low, never drive high
// - Rising direction edge restarts leg
// - Decode faulty element from fault flag and direction register
// - Toggle direction of legs reading zero
// - Then drive all pins low in window
// - Toggle alone clears when already low
// - Hold diag low to park half-bridge
module hbc_top
  import hbc_pkg::*;
#(
  parameter int PWM_PERIOD = PWM_PERIOD_CYC
) (
  input  wire logic        CLK,          // 125 MHz clock
  input  wire logic        CE,           // Clock enable
  input  wire logic        RESET,        // Sync reset, high
  input  wire logic [7:0]  ADDR,         // Register byte address
  input  wire logic [31:0] WDATA,        // Write data
  input  wire logic        WR,           // Write strobe
  input  wire logic        RD,           // Read strobe
  output logic      [31:0] RDATA,        // Read data, cycle after RD
  output logic             DIR_A,        // Leg A direction
  output logic             DIR_B,        // Leg B direction
  output logic             CHOP,         // Low-side chopping
  input  wire logic        DIAG_A_IN,    // Leg A diag level
  output logic             DIAG_A_OUT,   // Leg A drive value
  output logic             DIAG_A_OE_N,  // Leg A pull low, low active
  input  wire logic        DIAG_B_IN,    // Leg B diag level
  output logic             DIAG_B_OUT,   // Leg B drive value
  output logic             DIAG_B_OE_N   // Leg B pull low, low active
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    hbc_state_type               state;
    logic [LEGS-1:0]             dir;
    logic [LEGS-1:0]             en;
    logic [CNT_W-1:0]            duty;
    logic [CNT_W-1:0]            pwm_cnt;
    logic [CNT_W-1:0]            tcnt;
    logic [LEGS-1:0]             mask;
    logic                        to_sb;
    logic [LEGS-1:0]             fault;
    logic [LEGS-1:0][REL_W-1:0]  rel;
    logic [LEGS-1:0]             pin_dir;
    logic                        pin_chop;
    logic [LEGS-1:0]             pin_oe_n;
    logic [31:0]                 rdata;
  } hbc_top_type;

  localparam logic [CNT_W-1:0] TOG_LAST = CNT_W'(TOGGLE_CYC - 1);
  localparam logic [CNT_W-1:0] PWM_LAST = CNT_W'(PWM_PERIOD - 1);
  localparam int               SB_WIN   = ALL_LOW_CYC;

  hbc_top_type     st;
  hbc_top_type     next_st;
  logic [LEGS-1:0] diag;
  logic [LEGS-1:0] elem_hs;
  logic [LEGS-1:0] elem_ls;

  hbc_sync #(
    .WIDTH     (LEGS),
    .RESET_VAL (DIAG_RESET)
  ) u_sync (
    .clk   (CLK),
    .ce    (CE),
    .reset (RESET),
    .din   ({DIAG_B_IN, DIAG_A_IN}),
    .dout  (diag)
  );

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    next_st       = st;
    next_st.rdata = RD_ZERO;
    elem_hs       = st.fault & st.dir;
    elem_ls       = st.fault & ~st.dir;

    if (st.pwm_cnt >= PWM_LAST) begin
      next_st.pwm_cnt = '0;
    end else begin
      next_st.pwm_cnt = st.pwm_cnt + 1'b1;
    end

    // Released history hides pull-up rise and sampler lag
    for (int i = 0; i < LEGS; i++) begin
      next_st.rel[i] = {st.rel[i][REL_W-2:0], st.pin_oe_n[i]};
    end

    if (RD) begin
      unique case (ADDR)
        ADDR_CTRL: begin
          next_st.rdata[CTRL_DIR_LSB +: LEGS] = st.dir;
          next_st.rdata[CTRL_EN_LSB +: LEGS]  = st.en;
        end
        ADDR_DUTY:   next_st.rdata[CNT_W-1:0] = st.duty;
        ADDR_CMD:    next_st.rdata[3:0] = st.state;
        ADDR_STATUS: begin
          next_st.rdata[ST_DIAG_LSB +: LEGS]  = diag;
          next_st.rdata[ST_FAULT_LSB +: LEGS] = st.fault;
          next_st.rdata[ST_ELEM_LSB +: 4]     =
            {elem_ls[1], elem_hs[1], elem_ls[0], elem_hs[0]};
        end
        default:     next_st.rdata = RD_ZERO;
      endcase
    end

    if (WR) begin
      unique case (ADDR)
        ADDR_CTRL: begin
          next_st.dir = WDATA[CTRL_DIR_LSB +: LEGS];
          next_st.en  = WDATA[CTRL_EN_LSB +: LEGS];
        end
        ADDR_DUTY:   next_st.duty = WDATA[CNT_W-1:0];
        ADDR_STATUS: next_st.fault = st.fault & ~WDATA[ST_FAULT_LSB +: LEGS];
        ADDR_CMD: begin
          if (st.state == ST_RUN &&
              (WDATA[CMD_RESTART] || WDATA[CMD_STANDBY])) begin
            next_st.state = ST_TG_LOW;
            next_st.mask  = ~diag;
            next_st.to_sb = WDATA[CMD_STANDBY];
            next_st.tcnt  = TOG_LAST;
          end else if (st.state == ST_STANDBY && WDATA[CMD_WAKE]) begin
            next_st.state = ST_RUN;
          end
        end
        default: ;
      endcase
    end

    // Device pulled a released line low; set wins over clear
    for (int i = 0; i < LEGS; i++) begin
      if (&st.rel[i] && !diag[i]) begin
        next_st.fault[i] = 1'b1;
      end
    end

    unique case (st.state)
      ST_RUN, ST_STANDBY: ;
      ST_TG_LOW: begin
        next_st.tcnt = st.tcnt - 1'b1;
        if (st.tcnt == '0) begin
          next_st.state = ST_TG_HIGH;
          next_st.tcnt  = TOG_LAST;
        end
      end
      ST_TG_HIGH: begin
        next_st.tcnt = st.tcnt - 1'b1;
        if (st.tcnt == '0) begin
          next_st.state = st.to_sb ? ST_STANDBY : ST_RUN;
        end
      end
    endcase

    // Pin values follow the state being entered
    next_st.pin_chop = (st.pwm_cnt < st.duty);
    next_st.pin_oe_n = next_st.en;
    unique case (next_st.state)
      ST_RUN:    next_st.pin_dir = next_st.dir;
      ST_TG_LOW: next_st.pin_dir = st.pin_dir & ~next_st.mask;
      ST_TG_HIGH: next_st.pin_dir = st.pin_dir | next_st.mask;
      ST_STANDBY: begin
        next_st.pin_dir  = '0;
        next_st.pin_chop = 1'b0;
        next_st.pin_oe_n = '0;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      st       <= '0;
      st.state <= ST_RUN;
    end else if (CE) begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign RDATA       = st.rdata;
  assign DIR_A       = st.pin_dir[0];
  assign DIR_B       = st.pin_dir[1];
  assign CHOP        = st.pin_chop;
  assign DIAG_A_OUT  = 1'b0;
  assign DIAG_B_OUT  = 1'b0;
  assign DIAG_A_OE_N = st.pin_oe_n[0];
  assign DIAG_B_OE_N = st.pin_oe_n[1];

  // ****************************************************************
  // Assertions
  // ****************************************************************
  no_high_drive_a: assert property (@(posedge CLK) disable iff (RESET)
    (!DIAG_A_OE_N || !DIAG_B_OE_N) |-> !(DIAG_A_OUT || DIAG_B_OUT))
    else $error("diag line driven high");

  park_low_a: assert property (@(posedge CLK) disable iff (RESET)
    (CE && next_st.state == ST_RUN && !next_st.en[0])
    |=> !DIAG_A_OE_N)
    else $error("disabled leg A not pulled low");

  mask_low_a: assert property (@(posedge CLK) disable iff (RESET)
    (st.state == ST_TG_LOW && st.mask[1]) |-> !DIR_B)
    else $error("masked leg B direction not low");

  toggle_rise_a: assert property (@(posedge CLK) disable iff (RESET)
    (CE && st.state == ST_TG_LOW && st.tcnt == '0 && st.mask[0])
    |=> $rose(DIR_A))
    else $error("leg A direction did not rise");

  sb_window_a: assert property (@(posedge CLK) disable iff (RESET)
    (CE && st.state == ST_TG_HIGH && st.to_sb && st.tcnt == '0)
    |-> ##[1:SB_WIN] (!DIR_A && !DIR_B && !CHOP &&
                      !DIAG_A_OE_N && !DIAG_B_OE_N))
    else $error("pins not all low within window");

  standby_low_a: assert property (@(posedge CLK) disable iff (RESET)
    (st.state == ST_STANDBY && $past(st.state) == ST_STANDBY)
    |-> (!DIR_A && !DIR_B && !CHOP && !DIAG_A_OE_N && !DIAG_B_OE_N))
    else $error("standby pins not low");

  fault_set_a: assert property (@(posedge CLK) disable iff (RESET)
    (CE && (&st.rel[0]) && !diag[0]) |=> st.fault[0])
    else $error("leg A fault not latched");

  chop_zero_a: assert property (@(posedge CLK) disable iff (RESET)
    (CE && st.duty == '0 && next_st.state == ST_RUN) |=> !CHOP)
    else $error("chop high with zero duty");

  read_once_a: assert property (@(posedge CLK) disable iff (RESET)
    (CE && !RD) |=> (RDATA == RD_ZERO))
    else $error("read data outside read slot");

endmodule : hbc_top

// ===== tb/hbc_dev_model.sv
// Behavioural model of the bridge driver that the controller drives.
// Assumes line levels are resolved outside; pull_* asks to pull low.
`timescale 1ns/10ps
module hbc_dev_model (
  input  wire logic dir_a,            // Leg A direction
  input  wire logic dir_b,            // Leg B direction
  input  wire logic chop,             // Chopping input
  input  wire logic en_a,             // Leg A line level
  input  wire logic en_b,             // Leg B line level
  input  wire logic fault_a,          // Leg A fault flag
  input  wire logic fault_b,          // Leg B fault flag
  output logic      pull_a,           // Leg A fault pull-down
  output logic      pull_b,           // Leg B fault pull-down
  output logic      leg_a_low_switch, // Leg A low side on
  output logic      leg_b_low_switch, // Leg B low side on
  output logic      standby           // Standby entered
);
  logic lat_a = 1'b0;
  logic lat_b = 1'b0;
  logic fa_q  = 1'b0;
  logic fb_q  = 1'b0;
  logic da_q  = 1'b0;
  logic db_q  = 1'b0;
  // One process per latch: fault rise sets, direction rise clears
  always @(fault_a or dir_a) begin
    if (fault_a === 1'b1 && fa_q !== 1'b1) lat_a = 1'b1;
    if (dir_a === 1'b1 && da_q !== 1'b1) lat_a = 1'b0;
    fa_q = fault_a;
    da_q = dir_a;
  end
  always @(fault_b or dir_b) begin
    if (fault_b === 1'b1 && fb_q !== 1'b1) lat_b = 1'b1;
    if (dir_b === 1'b1 && db_q !== 1'b1) lat_b = 1'b0;
    fb_q = fault_b;
    db_q = dir_b;
  end
  assign pull_a = lat_a;
  assign pull_b = lat_b;
  assign leg_a_low_switch = en_a & ~lat_a & chop & ~dir_a;
  assign leg_b_low_switch = en_b & ~lat_b & chop & ~dir_b;
  assign standby = ~(dir_a | dir_b | chop | en_a | en_b | lat_a | lat_b);
endmodule : hbc_dev_model

// ===== tb/testbench.sv
// Register-level bench for the bridge host controller.
// Assumes pull-ups on both lines and the device model as far side.
`timescale 1ns/10ps
module testbench
  import hbc_pkg::*;
;
  logic        CLK = 0, RESET = 1, WR = 0, RD = 0, CE = 1;
  logic [7:0]  ADDR = 8'h00;
  logic [31:0] WDATA = 32'h0, RDATA, d;
  logic        DIR_A, DIR_B, CHOP, A_OUT, A_OE_N, B_OUT, B_OE_N;
  logic        fault_a = 0, fault_b = 0, pull_a, pull_b, low_a, low_b, stby;
  wire         line_a = ~((~A_OE_N & ~A_OUT) | pull_a);
  wire         line_b = ~((~B_OE_N & ~B_OUT) | pull_b);
  int          error_cnt = 0, checked = 0, hi;

  initial forever #4 CLK = ~CLK;

  hbc_top #(.PWM_PERIOD(16)) dut_u (.CLK(CLK), .CE(CE), .RESET(RESET),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .DIR_A(DIR_A), .DIR_B(DIR_B), .CHOP(CHOP), .DIAG_A_IN(line_a),
    .DIAG_A_OUT(A_OUT), .DIAG_A_OE_N(A_OE_N), .DIAG_B_IN(line_b),
    .DIAG_B_OUT(B_OUT), .DIAG_B_OE_N(B_OE_N));

  hbc_dev_model dev_u (.dir_a(DIR_A), .dir_b(DIR_B), .chop(CHOP),
    .en_a(line_a), .en_b(line_b), .fault_a(fault_a), .fault_b(fault_b),
    .pull_a(pull_a), .pull_b(pull_b), .leg_a_low_switch(low_a),
    .leg_b_low_switch(low_b), .standby(stby));

  // ****************************************************************
  // Bus tasks and checks
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= v;
    WR <= 1;
    @(posedge CLK);
    WR <= 0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1;
    @(posedge CLK);
    RD <= 0;
    #1 chk(RDATA, exp);
  endtask : rd

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge CLK);
  endtask : wait_cyc

  task automatic final_report;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report

  initial begin
    wait_cyc(20000);
    error_cnt++;
    final_report();
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    wait_cyc(8);
    RESET <= 0;
    rd(ADDR_CTRL, 32'h0);
    rd(ADDR_CMD, 32'h1);
    rd(ADDR_STATUS, 32'h0);
    rd(8'h10, 32'h0);
    wr(8'h10, 32'hF);
    wr(ADDR_DUTY, 32'h8);
    rd(ADDR_DUTY, 32'h8);
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_CTRL, 32'hC | m);
      wait_cyc(8);
      hi = 0;
      repeat (16) begin
        @(posedge CLK);
        #1 hi += CHOP;
        chk({DIR_B, DIR_A}, m[1:0]);
        chk(low_a, CHOP & ~m[0]);
        chk(low_b, CHOP & ~m[1]);
        chk({A_OUT, B_OUT, A_OE_N, B_OE_N}, 4'h3);
      end
      chk(hi, 8);
    end
    @(posedge CLK);
    CE <= 0;
    #1 hi = CHOP;
    repeat (16) begin
      @(posedge CLK);
      #1 chk(CHOP, hi);
    end
    @(posedge CLK);
    CE <= 1;
    rd(ADDR_STATUS, 32'h3);
    wr(ADDR_CTRL, 32'hD);
    wait_cyc(4);
    fault_a <= 1;
    wait_cyc(12);
    chk(low_a | pull_a, 1'b1);
    rd(ADDR_STATUS, 32'h16);
    fault_a <= 0;
    wait_cyc(4);
    rd(ADDR_STATUS, 32'h16);
    wr(ADDR_CMD, 32'h1);
    wait_cyc(260);
    rd(ADDR_CMD, 32'h1);
    chk(pull_a, 1'b0);
    wr(ADDR_STATUS, 32'hC);
    rd(ADDR_STATUS, 32'h3);
    fault_b <= 1;
    wait_cyc(12);
    rd(ADDR_STATUS, 32'h89);
    wr(ADDR_STATUS, 32'h8);
    rd(ADDR_STATUS, 32'h89);
    wr(ADDR_CMD, 32'h2);
    wait_cyc(260);
    rd(ADDR_CMD, 32'h8);
    chk({DIR_A, DIR_B, CHOP, A_OE_N, B_OE_N}, 0);
    chk(stby, 1'b1);
    wr(ADDR_CMD, 32'h1);
    rd(ADDR_CMD, 32'h8);
    wr(ADDR_CMD, 32'h4);
    rd(ADDR_CMD, 32'h1);
    @(posedge CLK);
    RESET <= 1;
    wait_cyc(2);
    RESET <= 0;
    rd(ADDR_CTRL, 32'h0);
    rd(ADDR_CMD, 32'h1);
    rd(ADDR_STATUS, 32'h0);
    chk({DIR_A, DIR_B, CHOP, A_OE_N, B_OE_N}, 0);
    final_report();
  end
endmodule : testbench
